// *** design/porst_defines.svh ***
// Constants for the power-on and brown-out reset sequencer.
`ifndef PORST_DEFINES_SVH
`define PORST_DEFINES_SVH

// ***************************************************************
// Clock and delays
// ***************************************************************
`define PORST_CLOCK_HZ        10000000
`define PORST_POR_SETTLE_US   30
`define PORST_BOR_SETTLE_US   100
`define PORST_TIMER_MAX_MS    128
`define PORST_TIMER_STEP_MS   2
`define PORST_TIMER_STEP_CYC  20000

// ***************************************************************
// Fields
// ***************************************************************
`define PORST_SEL_W           3
`define PORST_SEL_SETTINGS    8
`define PORST_CAUSE_W         2
`define PORST_CAUSE_POR_BIT   0
`define PORST_CAUSE_BOR_BIT   1
`define PORST_CAUSE_RESET     2'h1
`define PORST_SYNC_POK_BIT    0
`define PORST_SYNC_BLO_BIT    1
`define PORST_SYNC_RESET      2'h2

`endif

// *** design/porst_pkg.sv ***
// Types for the power-on and brown-out reset sequencer.
package porst_pkg;

    typedef enum logic [5:0] {
        PORST_WAIT_POR   = 6'h01,
        PORST_POR_SETTLE = 6'h02,
        PORST_BOR_HOLD   = 6'h04,
        PORST_BOR_SETTLE = 6'h08,
        PORST_TIMER      = 6'h10,
        PORST_RUN        = 6'h20
    } porst_state_t;

endpackage

// *** design/porst_top.sv ***
// Reset sequencer that releases system reset after supply checks and delays.
`include "porst_defines.svh"

module porst_top #(
    parameter int CNT_W            = 21,
    parameter int TIMER_STEP_CYCLES = `PORST_TIMER_STEP_CYC
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_poweron_ok,
    input  wire logic                      i_brownout_low,
    input  wire logic [`PORST_SEL_W-1:0]   i_powerup_delay_select,
    input  wire logic [`PORST_CAUSE_W-1:0] i_clear_cause,
    output logic                           o_system_reset_out,
    output logic                           o_powerup_timer_active,
    output logic [`PORST_CAUSE_W-1:0]      o_reset_cause_register
);

    // ***************************************************************
    // Derived cycle counts
    // ***************************************************************

    // Both settle delays are maxima, so integer division rounds down.
    localparam int CYC_PER_US  = `PORST_CLOCK_HZ / 1000000;
    localparam int POR_CYC_RAW = `PORST_POR_SETTLE_US * CYC_PER_US;
    localparam int BOR_CYC_RAW = `PORST_BOR_SETTLE_US * CYC_PER_US;
    localparam int POR_CYC     = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
    localparam int BOR_CYC     = (BOR_CYC_RAW < 1) ? 1 : BOR_CYC_RAW;
    localparam int TIMER_TOP   = TIMER_STEP_CYCLES * (`PORST_TIMER_MAX_MS / `PORST_TIMER_STEP_MS);

    localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_CYC - 1);
    localparam logic [CNT_W-1:0] BOR_LOAD = CNT_W'(BOR_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // ***************************************************************
    // Parameter checks
    // ***************************************************************

    generate
        if (TIMER_STEP_CYCLES < 1) begin : g_bad_step
            $error("Power-up timer step must be at least one cycle.");
        end
        if (TIMER_TOP >= (2 ** CNT_W) || BOR_CYC >= (2 ** CNT_W)) begin : g_bad_width
            $error("Counter width too small for the longest delay.");
        end
    endgenerate

    // ***************************************************************
    // Power-up timer settings
    // ***************************************************************

    // Setting zero skips the timer; setting one is one step, and each setting after it doubles it.
    logic [CNT_W-1:0] timer_table [`PORST_SEL_SETTINGS];

    genvar g;
    generate
        for (g = 0; g < `PORST_SEL_SETTINGS; g++) begin : g_timer
            if (g == 0) begin : g_zero
                assign timer_table[g] = '0;
            end else begin : g_step
                assign timer_table[g] = CNT_W'(TIMER_STEP_CYCLES * (2 ** (g - 1)));
            end
        end
    endgenerate

    logic [CNT_W-1:0] timer_len;

    assign timer_len = timer_table[i_powerup_delay_select];

    // ***************************************************************
    // Comparator synchronisers
    // ***************************************************************

    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic       poweron_ok;
    logic       brownout_low;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sync1_reg <= `PORST_SYNC_RESET;
            sync2_reg <= `PORST_SYNC_RESET;
        end else begin
            sync1_reg <= {i_brownout_low, i_poweron_ok};
            sync2_reg <= sync1_reg;
        end
    end

    assign poweron_ok   = sync2_reg[`PORST_SYNC_POK_BIT];
    assign brownout_low = sync2_reg[`PORST_SYNC_BLO_BIT];

    // ***************************************************************
    // Sequencer state machine
    // ***************************************************************

    porst_pkg::porst_state_t state_reg;
    porst_pkg::porst_state_t state_next;
    logic [CNT_W-1:0]        cnt_reg;
    logic [CNT_W-1:0]        cnt_next;
    logic                    cnt_done;

    assign cnt_done = (cnt_reg == '0);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if (!poweron_ok) begin
            state_next = porst_pkg::PORST_WAIT_POR;
            cnt_next   = '0;
        end else begin
            case (state_reg)
                porst_pkg::PORST_WAIT_POR: begin
                    state_next = porst_pkg::PORST_POR_SETTLE;
                    cnt_next   = POR_LOAD;
                end
                porst_pkg::PORST_POR_SETTLE: begin
                    if (!cnt_done) begin
                        cnt_next = cnt_reg - CNT_ONE;
                    end else if (brownout_low) begin
                        state_next = porst_pkg::PORST_BOR_HOLD;
                    end else begin
                        state_next = porst_pkg::PORST_BOR_SETTLE;
                        cnt_next   = BOR_LOAD;
                    end
                end
                porst_pkg::PORST_BOR_HOLD: begin
                    if (!brownout_low) begin
                        state_next = porst_pkg::PORST_BOR_SETTLE;
                        cnt_next   = BOR_LOAD;
                    end
                end
                porst_pkg::PORST_BOR_SETTLE: begin
                    if (brownout_low) begin
                        state_next = porst_pkg::PORST_BOR_HOLD;
                    end else if (!cnt_done) begin
                        cnt_next = cnt_reg - CNT_ONE;
                    end else if (timer_len == '0) begin
                        state_next = porst_pkg::PORST_RUN;
                    end else begin
                        state_next = porst_pkg::PORST_TIMER;
                        cnt_next   = timer_len - CNT_ONE;
                    end
                end
                porst_pkg::PORST_TIMER: begin
                    if (brownout_low) begin
                        state_next = porst_pkg::PORST_BOR_HOLD;
                    end else if (!cnt_done) begin
                        cnt_next = cnt_reg - CNT_ONE;
                    end else begin
                        state_next = porst_pkg::PORST_RUN;
                    end
                end
                porst_pkg::PORST_RUN: begin
                    if (brownout_low) begin
                        state_next = porst_pkg::PORST_BOR_HOLD;
                    end
                end
                default: begin
                    state_next = porst_pkg::PORST_WAIT_POR;
                    cnt_next   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_reg <= porst_pkg::PORST_WAIT_POR;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ***************************************************************
    // System reset output
    // ***************************************************************

    logic sys_reset_reg;
    logic timer_active_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sys_reset_reg    <= 1'b1;
            timer_active_reg <= 1'b0;
        end else begin
            sys_reset_reg    <= (state_next != porst_pkg::PORST_RUN);
            timer_active_reg <= (state_next == porst_pkg::PORST_TIMER);
        end
    end

    assign o_system_reset_out     = sys_reset_reg;
    assign o_powerup_timer_active = timer_active_reg;

    // ***************************************************************
    // Reset cause flags
    // ***************************************************************

    // A cause event in the same cycle as its clear leaves the flag set.
    logic [`PORST_CAUSE_W-1:0] cause_reg;
    logic [`PORST_CAUSE_W-1:0] cause_set;
    logic                      bor_event;

    // A supply collapse out of a running sequence is a brown-out as well.
    assign bor_event = brownout_low &&
                       ((state_reg == porst_pkg::PORST_BOR_SETTLE) ||
                        (state_reg == porst_pkg::PORST_TIMER) ||
                        (state_reg == porst_pkg::PORST_RUN) ||
                        ((state_next == porst_pkg::PORST_BOR_HOLD) &&
                         (state_reg != porst_pkg::PORST_BOR_HOLD)));

    always_comb begin
        cause_set                       = '0;
        cause_set[`PORST_CAUSE_POR_BIT] = (state_reg == porst_pkg::PORST_WAIT_POR);
        cause_set[`PORST_CAUSE_BOR_BIT] = bor_event;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cause_reg <= `PORST_CAUSE_RESET;
        end else begin
            cause_reg <= cause_set | (cause_reg & ~i_clear_cause);
        end
    end

    assign o_reset_cause_register = cause_reg;

endmodule

// *** sim/porst_checker.sv ***
// Port assertions for the reset sequencer.
`include "porst_defines.svh"
module porst_checker #(
    parameter int CNT_W            = 21,
    parameter int TIMER_STEP_CYCLES = `PORST_TIMER_STEP_CYC
) (
    input wire logic                      i_clock,
    input wire logic                      i_rst_n,
    input wire logic                      i_poweron_ok,
    input wire logic                      i_brownout_low,
    input wire logic [`PORST_SEL_W-1:0]   i_powerup_delay_select,
    input wire logic [`PORST_CAUSE_W-1:0] i_clear_cause,
    input wire logic                      o_system_reset_out,
    input wire logic                      o_powerup_timer_active,
    input wire logic [`PORST_CAUSE_W-1:0] o_reset_cause_register
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic [CNT_W-1:0] run_len_reg;
    // Counts the cycles of the current timer run.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !o_powerup_timer_active) begin
            run_len_reg <= '0;
        end else begin
            run_len_reg <= run_len_reg + 1'b1;
        end
    end
    a_por_hold: assert property ((!i_poweron_ok)[*4] |-> o_system_reset_out)
        else $error("reset released without supply");
    a_por_flag: assert property ((!i_poweron_ok)[*5] |-> o_reset_cause_register[0])
        else $error("power-on cause not set");
    a_bor_hold: assert property (i_brownout_low[*4] |-> o_system_reset_out)
        else $error("reset released in brown-out");
    a_bor_flag: assert property (!o_system_reset_out ##1 (i_brownout_low && !i_clear_cause[1])[*5]
        |-> o_reset_cause_register[1]) else $error("brown-out cause not set");
    a_timer_in_reset: assert property (o_powerup_timer_active |-> o_system_reset_out)
        else $error("timer runs outside reset");
    a_timer_length: assert property ($fell(o_powerup_timer_active) && !o_system_reset_out
        |-> run_len_reg == CNT_W'(TIMER_STEP_CYCLES << (i_powerup_delay_select - 3'h1)))
        else $error("timer length wrong");
    a_sticky_bor: assert property (o_reset_cause_register[1] && !i_clear_cause[1]
        |=> o_reset_cause_register[1]) else $error("brown-out cause lost");
    a_clear_bor: assert property ((!i_brownout_low)[*4] ##0 (i_clear_cause[1] && !o_system_reset_out)
        |=> !o_reset_cause_register[1]) else $error("brown-out cause not cleared");
    c_release: cover property ($fell(o_system_reset_out));
    c_bor_entry: cover property ($rose(o_reset_cause_register[1]));
    c_timer_end: cover property ($fell(o_powerup_timer_active));
endmodule

// *** sim/porst_supply_model.sv ***
// Behavioural model of the two supply comparators.
module porst_supply_model #(
    parameter int POR_MV = 1800,
    parameter int BOR_MV = 2500
) (
    input  wire logic [15:0] i_vdd_mv,
    output logic             o_poweron_ok,
    output logic             o_brownout_low
);
    timeunit 1ns;
    timeprecision 1ns;
    assign o_poweron_ok   = (i_vdd_mv >= 16'(POR_MV));
    assign o_brownout_low = (i_vdd_mv < 16'(BOR_MV));
endmodule

// *** sim/test_porst_top.sv ***
// Self-checking bench for the reset sequencer.
`include "porst_defines.svh"
module test_porst_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STEP = 4;
    logic                      i_clock;
    logic                      i_rst_n;
    logic [15:0]               vdd_mv;
    logic                      i_poweron_ok;
    logic                      i_brownout_low;
    logic [`PORST_SEL_W-1:0]   i_powerup_delay_select;
    logic [`PORST_CAUSE_W-1:0] i_clear_cause;
    logic                      o_system_reset_out;
    logic                      o_powerup_timer_active;
    logic [`PORST_CAUSE_W-1:0] o_reset_cause_register;
    int                        mismatches;
    int                        checks_done;
    int                        cycles;
    porst_supply_model i_porst_supply_model (.i_vdd_mv(vdd_mv), .o_poweron_ok(i_poweron_ok),
        .o_brownout_low(i_brownout_low));
    porst_top #(.TIMER_STEP_CYCLES(STEP)) i_porst_top (.i_clock, .i_rst_n, .i_poweron_ok, .i_brownout_low,
        .i_powerup_delay_select, .i_clear_cause, .o_system_reset_out, .o_powerup_timer_active,
        .o_reset_cause_register);
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    // Cuts a hang short well after the planned run length.
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    function automatic int timer_len(int sel);
        return (sel == 0) ? 0 : STEP << (sel - 1);
    endfunction
    // Counts edges from a supply change until system reset falls.
    task automatic edges_to_release(int exp);
        int n;
        n = 0;
        while (o_system_reset_out !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
        check("release edges", n, exp);
    endtask
    task automatic pulse_clear(logic [1:0] bits);
        i_clear_cause = bits;
        tick(1);
        i_clear_cause = 2'h0;
    endtask
    task automatic t_power_up(int sel);
        vdd_mv = 16'h0000;
        tick(8);
        pulse_clear(2'h3);
        check("cause when dead", o_reset_cause_register, 2'h1);
        i_powerup_delay_select = 3'(sel);
        vdd_mv = 16'h0ce4;
        edges_to_release(1303 + timer_len(sel));
        check("cause after start", o_reset_cause_register, 2'h1);
        pulse_clear(2'h1);
        check("cause cleared", o_reset_cause_register, 2'h0);
    endtask
    // A dip below the brown-out level, with an optional second dip during the delays.
    task automatic t_brown_out(int again_after, int sel);
        i_powerup_delay_select = 3'(sel);
        vdd_mv = 16'h07d0;
        tick(6);
        check("reset in dip", o_system_reset_out, 1'b1);
        check("cause in dip", o_reset_cause_register, 2'h2);
        vdd_mv = 16'h0ce4;
        if (again_after > 0) begin
            tick(again_after);
            check("timer mid delay", o_powerup_timer_active, again_after >= 1003);
            vdd_mv = 16'h07d0;
            tick(6);
            vdd_mv = 16'h0ce4;
        end
        edges_to_release(1003 + timer_len(sel));
        pulse_clear(2'h2);
        check("brown-out cleared", o_reset_cause_register, 2'h0);
    endtask
    initial begin
        i_rst_n = 1'b0;
        vdd_mv = 16'h0000;
        i_powerup_delay_select = 3'h0;
        i_clear_cause = 2'h0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        tick(12);
        i_rst_n = 1'b1;
        check("reset at start", o_system_reset_out, 1'b1);
        check("timer at start", o_powerup_timer_active, 1'b0);
        check("cause at start", o_reset_cause_register, 2'h1);
        for (int s = 0; s < 8; s++) begin
            t_power_up(s);
        end
        t_brown_out(0, 7);
        t_brown_out(500, 2);
        t_brown_out(1010, 4);
        give_verdict();
    end
endmodule
bind porst_top porst_checker #(.CNT_W(CNT_W), .TIMER_STEP_CYCLES(TIMER_STEP_CYCLES)) i_porst_checker (
    .i_clock, .i_rst_n, .i_poweron_ok, .i_brownout_low, .i_powerup_delay_select, .i_clear_cause,
    .o_system_reset_out, .o_powerup_timer_active, .o_reset_cause_register);
